// *** t1ec_chk_assertions.sv ***
`timescale 1ns/100ps
`default_nettype none
module t1ec_chk (
	// Watched ports
	input wire logic       CLK,
	input wire logic       RST,
	input wire logic       CE,
	input wire logic       UPDATE_INTERVAL_SELECT,
	input wire logic       ONE_SECOND_TICK,
	input wire logic       TICK_42MS,
	input wire logic [7:0] RD_ADDR,
	input wire logic [7:0] RD_DATA
);
	logic boundary;

	// Selected update tick, seen from the pins only
	assign boundary = UPDATE_INTERVAL_SELECT ? TICK_42MS : ONE_SECOND_TICK;

	AST_RST_CLEAR: assert property (@(posedge CLK) RST && CE |=>
		RD_DATA == 8'h00) else $error("read data not cleared by reset");
	AST_UNMAPPED: assert property (@(posedge CLK) disable iff (RST)
		CE && RD_ADDR > 8'h27 |=> RD_DATA == 8'h00)
		else $error("unmapped address read nonzero");
	AST_UNMAPPED_LOW: assert property (@(posedge CLK) disable iff (RST)
		CE && RD_ADDR < 8'h25 |=> RD_DATA == 8'h00)
		else $error("low unmapped address read nonzero");
	AST_CE_FREEZE: assert property (@(posedge CLK)
		!RST && !CE |=> $stable(RD_DATA))
		else $error("read data moved while clock enable low");
	AST_SNAP_HOLD: assert property (@(posedge CLK) disable iff (RST)
		!RST && CE && !boundary ##1 !RST && CE && $stable(RD_ADDR)
		|=> $stable(RD_DATA))
		else $error("held count changed without a boundary");
	AST_RST_ZERO: assert property (@(posedge CLK)
		RST ##1 !RST && CE && !boundary |=> RD_DATA == 8'h00)
		else $error("count nonzero before first boundary");
endmodule // t1ec_chk
bind t1ec_top t1ec_chk chk (.CLK(CLK), .RST(RST), .CE(CE),
	.UPDATE_INTERVAL_SELECT(UPDATE_INTERVAL_SELECT),
	.ONE_SECOND_TICK(ONE_SECOND_TICK), .TICK_42MS(TICK_42MS),
	.RD_ADDR(RD_ADDR), .RD_DATA(RD_DATA));
`default_nettype wire

// *** t1ec_pkg.sv ***
// Overview of operation
// R1: Path count is 12 bits, split nibble/byte.
// R2: D4 counts Ft (plus Fs optionally); ESF counts CRC6.
// R3: Shared byte: sync high nibble, path low nibble.
// R4: Mode one counts out-of-sync multiframes.
// R5: Out-of-sync counting continues during sync loss.
// R6: Mode zero counts Ft (D4) or FPS (ESF).
// R7: Framing-error sync counting held during sync loss.
// R8: Sync count 12 bits, low byte separate.
// R9: Update at second or 42 ms boundary.
// R10: Counters saturate, never roll over.
// R11: Path counter held during sync loss.
// R12: Software reads within one interval.
// R13: Boundary copies counts, restarts running counts.
package t1ec_pkg;
	localparam int         CNT_W          = 12;
	localparam logic [7:0] ADDR_SHARED_HI = 8'h25;
	localparam logic [7:0] ADDR_PATH_LO   = 8'h26;
	localparam logic [7:0] ADDR_SYNC_LO   = 8'h27;
	localparam int         HI_NIB_POS     = 4;
	localparam int         LO_NIB_POS     = 0;
	localparam logic [11:0] CNT_RESET     = 12'h000;
	localparam logic [11:0] CNT_MAX       = 12'hFFF;
endpackage : t1ec_pkg

// *** t1ec_sat_counter.sv ***
`timescale 1ns/100ps
`default_nettype none
module t1ec_sat_counter #(
	parameter int W = 12
) (
	// Clock and control
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         ce,
	// Counting
	input  wire logic         inc,
	input  wire logic         restart,
	output logic [W-1:0]      count_q,
	output logic [W-1:0]      snap_q
);
	// Restart takes the event of the same cycle so none is lost
	always_ff @(posedge clk) begin
		if (rst) begin
			count_q <= '0;
		end else if (ce) begin
			if (restart) begin
				count_q <= inc ? W'(1) : '0; // R13
			end else if (inc && count_q != {W{1'b1}}) begin
				count_q <= count_q + W'(1); // R10
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			snap_q <= '0;
		end else if (ce && restart) begin
			snap_q <= count_q; // R13
		end
	end
endmodule // t1ec_sat_counter
`default_nettype wire

// *** t1ec_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module t1ec_top (
	// Clock, reset, enable
	input  wire logic       CLK,
	input  wire logic       RST,
	input  wire logic       CE,
	// Configuration
	input  wire logic       FRAMING_MODE_SELECT,
	input  wire logic       FS_ERROR_COUNT_ENABLE,
	input  wire logic       SYNC_COUNTER_MODE_SELECT,
	input  wire logic       UPDATE_INTERVAL_SELECT,
	// Receive framer events, one-cycle strobes except RECEIVE_SYNC_LOST, a level held during sync loss
	input  wire logic       FT_ERROR,
	input  wire logic       FS_ERROR,
	input  wire logic       CRC6_ERROR,
	input  wire logic       FPS_ERROR,
	input  wire logic       MULTIFRAME,
	input  wire logic       RECEIVE_SYNC_LOST,
	input  wire logic       ONE_SECOND_TICK,
	input  wire logic       TICK_42MS,
	// Register read port
	input  wire logic [7:0] RD_ADDR,
	output logic [7:0]      RD_DATA
);
	logic boundary;
	logic path_inc;
	logic sync_inc;
	logic [11:0] path_cnt;
	logic [11:0] path_snap;
	logic [11:0] sync_cnt;
	logic [11:0] sync_snap;
	logic [7:0]  rd_d;

	////////////////////////////////////////////////////////////////////////
	// Event selection

	// Interval choice follows the selector live; a stray tick during a
	// change of selector just ends the interval early
	assign boundary = UPDATE_INTERVAL_SELECT ? TICK_42MS
		: ONE_SECOND_TICK; // R9

	always_comb begin
		if (RECEIVE_SYNC_LOST) begin
			path_inc = 1'b0; // R11
		end else if (FRAMING_MODE_SELECT) begin
			path_inc = CRC6_ERROR; // R2
		end else begin
			path_inc = FT_ERROR | (FS_ERROR_COUNT_ENABLE & FS_ERROR); // R2
		end
	end

	always_comb begin
		if (SYNC_COUNTER_MODE_SELECT) begin
			sync_inc = MULTIFRAME & RECEIVE_SYNC_LOST; // R4 R5
		end else if (RECEIVE_SYNC_LOST) begin
			sync_inc = 1'b0; // R7
		end else begin
			sync_inc = FRAMING_MODE_SELECT ? FPS_ERROR : FT_ERROR; // R6
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Counters

	t1ec_sat_counter #(.W(t1ec_pkg::CNT_W)) u_path ( // R1
		.clk     (CLK),
		.rst     (RST),
		.ce      (CE),
		.inc     (path_inc),
		.restart (boundary),
		.count_q (path_cnt),
		.snap_q  (path_snap)
	);

	t1ec_sat_counter #(.W(t1ec_pkg::CNT_W)) u_sync ( // R8
		.clk     (CLK),
		.rst     (RST),
		.ce      (CE),
		.inc     (sync_inc),
		.restart (boundary),
		.count_q (sync_cnt),
		.snap_q  (sync_snap)
	);

	////////////////////////////////////////////////////////////////////////
	// Read port, registered; it reads the snapshots, which stay put for one interval

	always_comb begin
		unique case (RD_ADDR)
			t1ec_pkg::ADDR_SHARED_HI: rd_d = {sync_snap[11:8],
				path_snap[11:8]}; // R3
			t1ec_pkg::ADDR_PATH_LO:   rd_d = path_snap[7:0]; // R1
			t1ec_pkg::ADDR_SYNC_LO:   rd_d = sync_snap[7:0]; // R8
			default:                  rd_d = 8'h00;
		endcase
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			RD_DATA <= 8'h00;
		end else if (CE) begin
			RD_DATA <= rd_d; // R3
		end
	end
endmodule // t1ec_top
`default_nettype wire

// *** tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic       clk = 0, rst = 1, fm = 0, fse = 0, sm = 0, uis = 0, lost = 0;
	logic       ft = 0, fs = 0, crc = 0, fps = 0, mf = 0, sec = 0, t42 = 0;
	logic [7:0] addr = 8'h00, data;
	logic       ce = 1;
	// Row: mode, fs enable, sync mode, lost, path[1:0], sync[1:0]
	logic [7:0] rows [6] = '{8'h05, 8'h49, 8'hE4, 8'hB1, 8'h50, 8'h85};
	int         fails = 0, comparisons = 0, cyc = 0;
	t1ec_top dut (.CLK(clk), .RST(rst), .CE(ce),
		.FRAMING_MODE_SELECT(fm), .FS_ERROR_COUNT_ENABLE(fse),
		.SYNC_COUNTER_MODE_SELECT(sm), .UPDATE_INTERVAL_SELECT(uis),
		.FT_ERROR(ft), .FS_ERROR(fs), .CRC6_ERROR(crc), .FPS_ERROR(fps),
		.MULTIFRAME(mf), .RECEIVE_SYNC_LOST(lost), .ONE_SECOND_TICK(sec),
		.TICK_42MS(t42), .RD_ADDR(addr), .RD_DATA(data));
	task automatic end_of_test();
		if (fails == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Called at a falling edge; data is checked one full cycle later
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		addr = a;
		@(negedge clk);
		comparisons++;
		if (data !== e) begin
			fails++;
			$display("[FAIL] RD_DATA at %h exp %h seen %h", a, e, data);
		end
	endtask
	initial forever #10 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc > 10000) begin
			fails++;
			end_of_test();
		end
	end
	initial begin
		repeat (5) @(negedge clk);
		rst = 0;
		foreach (rows[i]) begin
			{fm, fse, sm, lost} = rows[i][7:4];
			uis = i[0];
			for (int k = 0; k < 6; k++) begin
				{ft, fs, crc, fps, mf} = 5'h10 >> k;
				@(negedge clk);
			end
			{lost, t42, sec} = {1'b0, uis, !uis};
			@(negedge clk);
			{t42, sec} = 2'b00;
			rd(8'h26, {6'h00, rows[i][3:2]});
			rd(8'h27, {6'h00, rows[i][1:0]});
			rd(8'h25, 8'h00);
		end
		// Saturation: 4100 errors, just over the 4095 the count can hold
		{fm, sm, uis, ft} = 4'h1;
		repeat (4100) @(negedge clk);
		{ft, sec} = 2'b01;
		@(negedge clk);
		sec = 0;
		rd(8'h25, 8'hFF);
		rd(8'h26, 8'hFF);
		rd(8'h27, 8'hFF);
		rd(8'h28, 8'h00);
		// Frozen cycle: neither event nor boundary may land
		ce = 0;
		{ft, sec} = 2'b11;
		@(negedge clk);
		{ft, sec, ce} = 3'b001;
		rd(8'h26, 8'hFF);
		// Unselected tick only adds an event
		{ft, t42} = 2'b11;
		@(negedge clk);
		{ft, t42} = 2'b00;
		rd(8'h26, 8'hFF);
		// Event on a boundary goes into the new interval
		{ft, sec} = 2'b11;
		@(negedge clk);
		{ft, sec} = 2'b00;
		rd(8'h26, 8'h01);
		sec = 1;
		@(negedge clk);
		sec = 0;
		rd(8'h26, 8'h01);
		rd(8'h27, 8'h01);
		// Mid-run reset must drop the running count
		ft = 1;
		@(negedge clk);
		{ft, rst} = 2'b01;
		rd(8'h27, 8'h00);
		{rst, sec} = 2'b01;
		@(negedge clk);
		sec = 0;
		rd(8'h26, 8'h00);
		end_of_test();
	end
endmodule // tb
`default_nettype wire
